// ### hdl/scms_mode_select.sv
// Purpose: servo control mode decoder with AXI4-Lite setup registers
// Assumes: inputs synchronous to clock; speeds and commands are unsigned magnitudes
// Notes:   edited setup words take effect only at a power reset
//
// Notes on behaviour
// - mode 0,0 speed loop, pin drops gain
// - mode 0,1 speed loop, pin holds position
// - hold and slow motor gives position lock
// - mode 1,0 torque loop, pin ignored
// - mode 1,1 pin picks torque or speed
// - torque loop uses speed command as limit
// - over limit, braking torque follows excess
// - field d,C chooses P switch condition
// - P switch only in speed loop
// - bit E selects absolute encoder
// - bit F enables torque feed-forward
// - bit 5 auto-clears momentary stop alarm
// - bit 6 without 8 releases brake stopped
// - torque loop stops by bit 6 only
// - internal speed mode reinterprets field b,A
// - setup bits apply only after power reset
// - word two bit 2 selects internal speed
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module scms_mode_select (
    input  wire logic        clock,
    input  wire logic        resetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output      logic        s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output      logic        s_wready,
    output      logic [1:0]  s_bresp,
    output      logic        s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output      logic        s_arready,
    output      logic [31:0] s_rdata,
    output      logic [1:0]  s_rresp,
    output      logic        s_rvalid,
    input  wire logic        s_rready,
    // drive side
    input  wire logic        power_reset,
    input  wire logic        multi_function_pin,
    input  wire logic [15:0] speed_command_in,
    input  wire logic [15:0] torque_command_in,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] motor_accel,
    input  wire logic        motor_stopped,
    input  wire logic        momentary_stop_alarm,
    input  wire logic        fault_stop,
    input  wire logic        overtravel,
    output      logic [1:0]  control_loop,
    output      logic        p_control,
    output      logic [15:0] speed_limit,
    output      logic [15:0] limit_torque,
    output      logic        encoder_absolute,
    output      logic        torque_ff_enable,
    output      logic        alarm_auto_clear,
    output      logic        brake_relay_on,
    output      logic        free_run_stop,
    output      logic        overtravel_torque_stop,
    output      logic        internal_speed_mode,
    output      logic [1:0]  internal_speed_select,
    output      logic        irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        logic [15:0] setup_word_one;
        logic [15:0] setup_word_two;
        logic [15:0] act_one;
        logic [15:0] act_two;
        logic [15:0] lock_speed_threshold;
        logic [15:0] torque_switch_threshold;
        logic [15:0] speed_switch_threshold;
        logic [15:0] accel_switch_threshold;
        logic        sw_reset_req;
        logic        por_load;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        logic [1:0]  loop;
        logic        p_ctl;
        logic [15:0] spd_lim;
        logic [15:0] lim_trq;
        logic        brake;
        logic        free_run;
        logic        ot_torque;
        logic        auto_clr;
    } scms_state_t;

    scms_state_t st_r;
    scms_state_t st_nxt;

    // merge bus bytes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic              wr_go;
    logic              rd_go;
    scms_pkg::scms_mode_t mode;
    scms_pkg::scms_psw_t  psw;
    logic              int_spd;
    logic              speed_loop;
    logic              trq_loop;
    logic              lock_now;
    logic              psw_hit;
    logic              over_lim;
    logic [3:0]        evt;
    logic [31:0]       rd_val;

    always_comb begin
        st_nxt = st_r;
        // bus handshakes: address and data taken in either order
        if (s_awvalid && !st_r.aw_held) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_awaddr;
        end
        if (s_wvalid && !st_r.w_held) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_wdata;
            st_nxt.w_strb = s_wstrb;
        end
        wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        rd_go = s_arvalid && !st_r.rvalid;
        if (st_r.bvalid && s_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.rvalid && s_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // decode from active words only, never the shadow
        mode    = scms_pkg::scms_mode_t'(st_r.act_one[scms_pkg::BIT_MODE_LO +: 2]);
        psw     = scms_pkg::scms_psw_t'(st_r.act_one[scms_pkg::BIT_PSW_LO +: 2]);
        int_spd = st_r.act_two[scms_pkg::BIT_INT_SPEED];

        // loop choice; field b,A left to the internal speed block when selected
        lock_now = 1'b0;
        if (int_spd) begin
            speed_loop = 1'b1;
        end else begin
            unique case (mode)
                scms_pkg::SCMS_MODE_SPEED:  speed_loop = 1'b1;
                scms_pkg::SCMS_MODE_LOCK: begin
                    speed_loop = 1'b1;
                    lock_now   = multi_function_pin && (motor_speed < st_r.lock_speed_threshold);
                end
                scms_pkg::SCMS_MODE_TRQ_I:  speed_loop = 1'b0;
                scms_pkg::SCMS_MODE_TRQ_II: speed_loop = multi_function_pin;
            endcase
        end
        trq_loop = !speed_loop;
        if (lock_now) begin
            st_nxt.loop = scms_pkg::SCMS_LOOP_POS;
        end else if (trq_loop) begin
            st_nxt.loop = scms_pkg::SCMS_LOOP_TRQ;
        end else begin
            st_nxt.loop = scms_pkg::SCMS_LOOP_SPEED;
        end

        // P switch condition, speed loop only
        unique case (psw)
            scms_pkg::SCMS_PSW_TORQUE: psw_hit = torque_command_in > st_r.torque_switch_threshold;
            scms_pkg::SCMS_PSW_SPEED:  psw_hit = speed_command_in > st_r.speed_switch_threshold;
            scms_pkg::SCMS_PSW_ACCEL:  psw_hit = motor_accel > st_r.accel_switch_threshold;
            scms_pkg::SCMS_PSW_NONE:   psw_hit = 1'b0;
        endcase
        st_nxt.p_ctl = speed_loop && !lock_now && (psw_hit ||
            (!int_spd && mode == scms_pkg::SCMS_MODE_SPEED && multi_function_pin));

        // speed limit in torque loop; braking torque tracks the excess
        over_lim        = trq_loop && (motor_speed > speed_command_in);
        st_nxt.spd_lim  = trq_loop ? speed_command_in : 16'h0000;
        st_nxt.lim_trq  = over_lim ? 16'(motor_speed - speed_command_in) : 16'h0000;

        // stop behaviour: torque loop ignores bit 8
        st_nxt.free_run  = st_r.act_one[scms_pkg::BIT_FREE_RUN];
        st_nxt.ot_torque = trq_loop ? 1'b0 : st_r.act_one[scms_pkg::BIT_OT_TORQUE];
        if (st_r.act_one[scms_pkg::BIT_FREE_RUN] && !st_nxt.ot_torque) begin
            st_nxt.brake = fault_stop && !motor_stopped;
        end else begin
            st_nxt.brake = fault_stop && (!motor_stopped || st_r.act_one[scms_pkg::BIT_DB_HOLD]);
        end
        st_nxt.auto_clr = momentary_stop_alarm && st_r.act_one[scms_pkg::BIT_AUTO_CLR];

        // setup word writes go to the shadow copy only; thresholds, mask and control update at once
        if (wr_go) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            unique case (st_r.aw_addr)
                scms_pkg::OFS_SETUP_ONE:   st_nxt.setup_word_one = merge16(st_r.setup_word_one, st_r.w_data, st_r.w_strb);
                scms_pkg::OFS_SETUP_TWO:   st_nxt.setup_word_two = merge16(st_r.setup_word_two, st_r.w_data, st_r.w_strb);
                scms_pkg::OFS_THRESH_LOCK: st_nxt.lock_speed_threshold =
                    merge16(st_r.lock_speed_threshold, st_r.w_data, st_r.w_strb);
                scms_pkg::OFS_THRESH_TRQ:  st_nxt.torque_switch_threshold =
                    merge16(st_r.torque_switch_threshold, st_r.w_data, st_r.w_strb);
                scms_pkg::OFS_THRESH_SPD:  st_nxt.speed_switch_threshold =
                    merge16(st_r.speed_switch_threshold, st_r.w_data, st_r.w_strb);
                scms_pkg::OFS_THRESH_ACC:  st_nxt.accel_switch_threshold =
                    merge16(st_r.accel_switch_threshold, st_r.w_data, st_r.w_strb);
                scms_pkg::OFS_IRQ_MASK: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.irq_mask = st_r.w_data[3:0];
                    end
                end
                scms_pkg::OFS_CTRL: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.sw_reset_req = st_r.w_data[0];
                    end
                end
                default: ;
            endcase
        end

        // power reset transfer; shadow becomes active and the request self-clears on the same edge
        st_nxt.por_load = 1'b0;
        if (power_reset || st_r.sw_reset_req) begin
            st_nxt.act_one      = st_r.setup_word_one;
            st_nxt.act_two      = st_r.setup_word_two;
            st_nxt.sw_reset_req = 1'b0;
        end

        // register reads; status read clears, new events win over the clear
        unique case (s_araddr)
            scms_pkg::OFS_SETUP_ONE:   rd_val = {16'h0000, st_r.setup_word_one};
            scms_pkg::OFS_SETUP_TWO:   rd_val = {16'h0000, st_r.setup_word_two};
            scms_pkg::OFS_ACTIVE:      rd_val = {st_r.act_two, st_r.act_one};
            scms_pkg::OFS_THRESH_LOCK: rd_val = {16'h0000, st_r.lock_speed_threshold};
            scms_pkg::OFS_THRESH_TRQ:  rd_val = {16'h0000, st_r.torque_switch_threshold};
            scms_pkg::OFS_THRESH_SPD:  rd_val = {16'h0000, st_r.speed_switch_threshold};
            scms_pkg::OFS_THRESH_ACC:  rd_val = {16'h0000, st_r.accel_switch_threshold};
            scms_pkg::OFS_STATUS:      rd_val = {26'h0, st_r.brake, st_r.p_ctl, int_spd,
                                                 st_r.act_one[scms_pkg::BIT_ENC_ABS], st_r.loop};
            scms_pkg::OFS_IRQ_STAT:    rd_val = {28'h0, st_r.irq_stat};
            scms_pkg::OFS_IRQ_MASK:    rd_val = {28'h0, st_r.irq_mask};
            scms_pkg::OFS_CTRL:        rd_val = {31'h0, st_r.sw_reset_req};
            default:                   rd_val = 32'h0000_0000;
        endcase
        if (rd_go) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_val;
            if (s_araddr == scms_pkg::OFS_IRQ_STAT) begin
                st_nxt.irq_stat = 4'h0;
            end
        end
        evt = '0;
        evt[scms_pkg::IRQ_LOCK_ON]  = lock_now && st_r.loop != scms_pkg::SCMS_LOOP_POS;
        evt[scms_pkg::IRQ_PSW_ON]   = st_nxt.p_ctl && !st_r.p_ctl;
        evt[scms_pkg::IRQ_AUTO_CLR] = st_nxt.auto_clr && !st_r.auto_clr;
        evt[scms_pkg::IRQ_LIMITING] = over_lim && st_r.lim_trq == 16'h0000;
        st_nxt.irq_stat = st_nxt.irq_stat | evt;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset loads factory words so the decode is sane from the first edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r                         <= '0;
            st_r.setup_word_one          <= scms_pkg::RST_SETUP_ONE;
            st_r.setup_word_two          <= scms_pkg::RST_SETUP_TWO;
            st_r.act_one                 <= scms_pkg::RST_SETUP_ONE;
            st_r.act_two                 <= scms_pkg::RST_SETUP_TWO;
            st_r.lock_speed_threshold    <= scms_pkg::RST_THRESH;
            st_r.torque_switch_threshold <= scms_pkg::RST_THRESH;
            st_r.speed_switch_threshold  <= scms_pkg::RST_THRESH;
            st_r.accel_switch_threshold  <= scms_pkg::RST_THRESH;
            st_r.irq_mask                <= scms_pkg::RST_MASK;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_awready              = !st_r.aw_held;
    assign s_wready               = !st_r.w_held;
    assign s_bvalid               = st_r.bvalid;
    assign s_bresp                = 2'b00;
    assign s_arready              = !st_r.rvalid;
    assign s_rvalid               = st_r.rvalid;
    assign s_rdata                = st_r.rdata;
    assign s_rresp                = 2'b00;
    assign control_loop           = st_r.loop;
    assign p_control              = st_r.p_ctl;
    assign speed_limit            = st_r.spd_lim;
    assign limit_torque           = st_r.lim_trq;
    assign encoder_absolute       = st_r.act_one[scms_pkg::BIT_ENC_ABS];
    assign torque_ff_enable       = st_r.act_one[scms_pkg::BIT_TRQ_FF];
    assign alarm_auto_clear       = st_r.auto_clr;
    assign brake_relay_on         = st_r.brake;
    assign free_run_stop          = st_r.free_run;
    assign overtravel_torque_stop = st_r.ot_torque;
    assign internal_speed_mode    = st_r.act_two[scms_pkg::BIT_INT_SPEED];
    assign internal_speed_select  = st_r.act_one[scms_pkg::BIT_MODE_LO +: 2];
    assign irq                    = |(st_r.irq_stat & st_r.irq_mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_torque_i;
        @(posedge clock) disable iff (!resetn)
        (!st_r.act_two[scms_pkg::BIT_INT_SPEED] && st_r.act_one[11:10] == 2'b10)
            |=> control_loop == scms_pkg::SCMS_LOOP_TRQ;
    endproperty
    a_torque_i: assert property (p_torque_i) else $error("torque mode i not in torque loop");

    property p_lock;
        @(posedge clock) disable iff (!resetn)
        (!st_r.act_two[2] && st_r.act_one[11:10] == 2'b01 && multi_function_pin
            && motor_speed < st_r.lock_speed_threshold) |=> control_loop == scms_pkg::SCMS_LOOP_POS;
    endproperty
    a_lock: assert property (p_lock) else $error("position lock not taken");

    property p_psw_speed_only;
        @(posedge clock) disable iff (!resetn)
        control_loop == scms_pkg::SCMS_LOOP_TRQ |-> !p_control;
    endproperty
    a_psw_speed_only: assert property (p_psw_speed_only) else $error("p control in torque loop");

    property p_limit;
        @(posedge clock) disable iff (!resetn)
        ##1 control_loop == scms_pkg::SCMS_LOOP_TRQ |-> speed_limit == $past(speed_command_in);
    endproperty
    a_limit: assert property (p_limit) else $error("speed limit not from speed command");

    property p_apply_at_reset;
        @(posedge clock) disable iff (!resetn)
        (!power_reset && !st_r.sw_reset_req) |=> $stable(st_r.act_one);
    endproperty
    a_apply_at_reset: assert property (p_apply_at_reset) else $error("active word changed without reset");

    property p_brake_release;
        @(posedge clock) disable iff (!resetn)
        (st_r.act_one[6] && !st_nxt.ot_torque && motor_stopped) |=> !brake_relay_on;
    endproperty
    a_brake_release: assert property (p_brake_release) else $error("brake held after stop");

    property p_auto_clear;
        @(posedge clock) disable iff (!resetn)
        (momentary_stop_alarm && st_r.act_one[5]) |=> alarm_auto_clear;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("alarm not auto cleared");

    property p_no_psw;
        @(posedge clock) disable iff (!resetn)
        (st_r.act_one[13:12] == 2'b11 && st_r.act_one[11:10] != 2'b00) |=> !p_control;
    endproperty
    a_no_psw: assert property (p_no_psw) else $error("p switch active while disabled");
endmodule

// ### shared/scms_pkg.sv
// Purpose: constants and types for the servo control mode decoder
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   offsets are byte addresses
package scms_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SETUP_ONE   = 8'h00;  // shadow setup word one
    localparam logic [7:0] OFS_SETUP_TWO   = 8'h04;  // shadow setup word two
    localparam logic [7:0] OFS_ACTIVE      = 8'h08;  // active words, read only
    localparam logic [7:0] OFS_THRESH_LOCK = 8'h0c;
    localparam logic [7:0] OFS_THRESH_TRQ  = 8'h10;
    localparam logic [7:0] OFS_THRESH_SPD  = 8'h14;
    localparam logic [7:0] OFS_THRESH_ACC  = 8'h18;
    localparam logic [7:0] OFS_STATUS      = 8'h1c;  // control state, read only
    localparam logic [7:0] OFS_IRQ_STAT    = 8'h20;  // sticky events, clear on read
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h24;
    localparam logic [7:0] OFS_CTRL        = 8'h28;  // bit0 power reset request

    // ------------------------------------------------------------
    // field positions of setup word one
    // ------------------------------------------------------------
    localparam int BIT_AUTO_CLR  = 5;
    localparam int BIT_FREE_RUN  = 6;
    localparam int BIT_DB_HOLD   = 7;
    localparam int BIT_OT_TORQUE = 8;
    localparam int BIT_MODE_LO   = 10;
    localparam int BIT_PSW_LO    = 12;
    localparam int BIT_ENC_ABS   = 14;
    localparam int BIT_TRQ_FF    = 15;
    localparam int BIT_INT_SPEED = 2;  // in setup word two

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_SETUP_ONE = 16'h302c;  // factory bits 2,3,5 and d,C
    localparam logic [15:0] RST_SETUP_TWO = 16'h0000;
    localparam logic [15:0] RST_THRESH    = 16'h0000;
    localparam logic [3:0]  RST_MASK      = 4'h0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCMS_MODE_SPEED  = 2'b00,
        SCMS_MODE_LOCK   = 2'b01,
        SCMS_MODE_TRQ_I  = 2'b10,
        SCMS_MODE_TRQ_II = 2'b11
    } scms_mode_t;

    typedef enum logic [1:0] {
        SCMS_PSW_TORQUE = 2'b00,
        SCMS_PSW_SPEED  = 2'b01,
        SCMS_PSW_ACCEL  = 2'b10,
        SCMS_PSW_NONE   = 2'b11
    } scms_psw_t;

    typedef enum logic [1:0] {
        SCMS_LOOP_SPEED = 2'b00,
        SCMS_LOOP_POS   = 2'b01,
        SCMS_LOOP_TRQ   = 2'b10
    } scms_loop_t;

    // interrupt status bits
    localparam int IRQ_LOCK_ON  = 0;
    localparam int IRQ_PSW_ON   = 1;
    localparam int IRQ_AUTO_CLR = 2;
    localparam int IRQ_LIMITING = 3;
endpackage

// ### tb/scms_partner.sv
// Purpose: motor side model that feeds speed feedback to the decoder
// Assumes: motor speed follows the target after a fixed lag
// Notes:   accel is current minus next speed, the coming step negated; a real motor never jumps at once
`timescale 1ns/1ns
module scms_partner #(
    parameter int LAG = 3
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [15:0] target,
    output      logic [15:0] motor_speed,
    output      logic [15:0] motor_accel,
    output      logic        motor_stopped
);
    logic [15:0] pipe [LAG];
    // delay line standing in for rotor inertia
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < LAG; i++) pipe[i] <= 16'h0000;
        end else begin
            pipe[0] <= target;
            for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
        end
    end
    assign motor_speed   = pipe[LAG-1];
    assign motor_accel   = pipe[LAG-1] - pipe[LAG-2];
    assign motor_stopped = (motor_speed == 16'h0000);
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for the servo mode decoder
// Assumes: ready and valid are looked at mid-cycle, taken at the next rising edge
// Notes:   expectations come from bench functions, never from outputs
`timescale 1ns/1ns
module testbench;
    logic        clock, resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, power_reset;
    logic        multi_function_pin, momentary_stop_alarm, motor_stopped, s_awready, s_wready, s_bvalid;
    logic        s_arready, s_rvalid, p_control, encoder_absolute, torque_ff_enable, alarm_auto_clear;
    logic        brake_relay_on, overtravel_torque_stop, irq, fault_stop, internal_speed_mode;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, lfsr, v;
    logic [15:0] speed_command_in, torque_command_in, motor_speed, motor_accel, target, w, speed_limit, limit_torque;
    logic [1:0]  control_loop, lp, internal_speed_select;
    int          n_errors, cmp_count, cyc;
    scms_mode_select scms_mode_select_i (.clock, .resetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp(), .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp(), .s_rvalid, .s_rready, .power_reset, .multi_function_pin, .speed_command_in,
        .torque_command_in, .motor_speed, .motor_accel, .motor_stopped, .momentary_stop_alarm, .fault_stop,
        .overtravel(1'b0), .control_loop, .p_control, .speed_limit, .limit_torque, .encoder_absolute,
        .torque_ff_enable, .alarm_auto_clear, .brake_relay_on, .free_run_stop(), .overtravel_torque_stop,
        .internal_speed_mode, .internal_speed_select, .irq);
    scms_partner scms_partner_i (.clock, .resetn, .target, .motor_speed, .motor_accel, .motor_stopped);
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] exp_loop(input logic [1:0] m, input logic p, input logic lk);
        if (m == 2'b10 || (m == 2'b11 && !p)) return 2'd2;
        return (m == 2'b01 && p && lk) ? 2'd1 : 2'd0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        @(posedge clock);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(negedge clock);
            ah = s_awvalid && s_awready;
            wh = s_wvalid && s_wready;
            bh = s_bvalid;
            @(posedge clock);
            if (ah) s_awvalid <= 1'b0;
            if (wh) s_wvalid <= 1'b0;
        end while (!bh);
        s_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic h;
        @(posedge clock);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(negedge clock);
            h = s_arready;
            @(posedge clock);
        end while (!h);
        s_arvalid <= 1'b0;
        do begin
            @(negedge clock);
            h = s_rvalid;
            d = s_rdata;
            @(posedge clock);
        end while (!h);
        s_rready <= 1'b0;
    endtask
    // shadow edit, then a power reset pulse to make it live
    task automatic cfg(input logic [15:0] x);
        wr(scms_pkg::OFS_SETUP_ONE, {16'h0000, x});
        power_reset <= 1'b1;
        @(posedge clock);
        power_reset <= 1'b0;
    endtask
    task automatic go(input logic p, input logic [15:0] sc, input logic [15:0] tg, input logic al);
        @(posedge clock);
        multi_function_pin   <= p;
        speed_command_in     <= sc;
        target               <= tg;
        momentary_stop_alarm <= al;
        repeat (7) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, power_reset, fault_stop} = '0;
        {multi_function_pin, momentary_stop_alarm, s_awaddr, s_araddr, s_wdata} = '0;
        {speed_command_in, target} = '0;
        torque_command_in = 16'h0123;
        lfsr = 32'h1055;
        {n_errors, cmp_count, cyc} = '0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        rd(scms_pkg::OFS_SETUP_ONE, v); chk(v, 32'h302c);
        rd(scms_pkg::OFS_ACTIVE, v); chk(v, 32'h302c);
        rd(8'h3c, v); chk(v, 32'h0);
        fault_stop <= 1'b1;
        go(1'b0, 16'h0, 16'h0050, 1'b0); chk(brake_relay_on, 1'b1);
        go(1'b0, 16'h0, 16'h0, 1'b0); chk(brake_relay_on, 1'b0);
        $display("test reset done");
        wr(scms_pkg::OFS_SETUP_ONE, 32'h382c);
        go(1'b0, 16'h0100, 16'h0200, 1'b0); chk(control_loop, 2'd0);
        wr(scms_pkg::OFS_CTRL, 32'h1);
        go(1'b0, 16'h0100, 16'h0200, 1'b0); chk(control_loop, 2'd2);
        $display("test hold done");
        wr(scms_pkg::OFS_THRESH_LOCK, 32'h40);
        for (int k = 0; k < 8; k++) begin
            lfsr = nx(nx(nx(lfsr)));
            w = {lfsr[15:14], 2'b11, lfsr[11:10], 1'b0, lfsr[8], 2'b01, lfsr[5], 5'b01100};
            cfg(w);
            rd(scms_pkg::OFS_ACTIVE, v); chk(v, {16'h0, w});
            v = {8'h0, lfsr[31:24], 9'h0, lfsr[22:16]};
            go(lfsr[0], v[31:16], v[15:0], lfsr[3]);
            lp = exp_loop(w[11:10], lfsr[0], lfsr[22:16] < 7'h40);
            chk(control_loop, lp);
            chk(p_control, w[11:10] == 2'b00 && lfsr[0]);
            chk({encoder_absolute, torque_ff_enable}, {w[14], w[15]});
            chk(alarm_auto_clear, w[5] && lfsr[3]);
            chk(overtravel_torque_stop, w[8] && lp != 2'd2);
            chk(speed_limit, lp == 2'd2 ? v[31:16] : 16'h0);
            chk(limit_torque, lp == 2'd2 && v[15:0] > v[31:16] ? v[15:0] - v[31:16] : 16'h0);
        end
        wr(scms_pkg::OFS_SETUP_TWO, 32'h4);
        cfg(16'h382c);
        go(1'b0, 16'h0100, 16'h0200, 1'b0); chk({internal_speed_mode, internal_speed_select, control_loop}, 5'h18);
        wr(scms_pkg::OFS_SETUP_TWO, 32'h0);
        $display("test modes done");
        wr(scms_pkg::OFS_THRESH_SPD, 32'h80);
        cfg(16'h102c);
        go(1'b0, 16'h0100, 16'h0, 1'b0); chk(p_control, 1'b1);
        cfg(16'h182c);
        go(1'b0, 16'h0100, 16'h0, 1'b0); chk(p_control, 1'b0);
        $display("test pswitch done");
        cfg(16'h342c);
        go(1'b1, 16'h0, 16'h000a, 1'b0); chk(irq, 1'b0);
        rd(scms_pkg::OFS_IRQ_STAT, v); chk(v[0], 1'b1);
        wr(scms_pkg::OFS_IRQ_MASK, 32'h1);
        go(1'b0, 16'h0, 16'h000a, 1'b0);
        go(1'b1, 16'h0, 16'h000a, 1'b0); chk(irq, 1'b1);
        rd(scms_pkg::OFS_IRQ_STAT, v);
        go(1'b1, 16'h0, 16'h000a, 1'b0); chk(irq, 1'b0);
        $display("test irq done");
        report_and_stop();
    end
endmodule
